// *** dram_glue.sv ***
/*
 * cpu to dram controller glue: row-cycle start, byte column strobes,
 * transfer acknowledge with optional wait state, forced refresh, and an
 * axi4-lite port for a refresh control word and status.
 * assumes cpu bus pins arrive synchronous to clk, active low.
 */

`timescale 1ns/1ps

module dram_glue (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // cpu side
  input  wire logic        cpu_addr_strobe_n,
  input  wire logic        upper_data_strobe_n,
  input  wire logic        lower_data_strobe_n,
  input  wire logic        read_write,
  input  wire logic        speed_select,
  input  wire logic        dram_chip_select_n,
  output logic             transfer_ack_n_o,
  output logic             transfer_ack_oe,
  // dram controller side
  input  wire logic        col_strobe_n,
  input  wire logic        refresh_request_n,
  output logic             row_cycle_start_n,
  output logic             upper_byte_col_strobe_n,
  output logic             lower_byte_col_strobe_n,
  output logic             refresh_mode_out_n,
  // axi4-lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ****************************************
  // reset release
  // ****************************************
  logic       rst_meta_q;
  logic       rst_sync_n;

  // two flops so release never lands mid-setup
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // ****************************************
  // active-high views of the pins
  // ****************************************
  logic addr_act;
  logic uds_act;
  logic lds_act;
  logic ds_any;
  logic cas_act;
  logic cs_act;
  logic slow_cfg;
  logic fast_cfg;
  logic req_act;

  assign addr_act = ~cpu_addr_strobe_n;
  assign uds_act  = ~upper_data_strobe_n;
  assign lds_act  = ~lower_data_strobe_n;
  assign ds_any   = uds_act | lds_act;
  assign cas_act  = ~col_strobe_n;
  assign cs_act   = ~dram_chip_select_n;
  // read/write only means configuration while speed-select is high
  assign slow_cfg = speed_select & read_write;
  assign fast_cfg = speed_select & ~read_write;

  // ****************************************
  // register file state
  // ****************************************
  logic        soft_req_q;
  logic        inhibit_q;
  logic [15:0] refresh_count_q;

  // the timer request, a software request, gated by the inhibit bit
  assign req_act = (~refresh_request_n | soft_req_q) & ~inhibit_q;

  // ****************************************
  // refresh sequencer
  // ****************************************
  logic                              refresh_mode_out_q;
  logic                              refresh_mode_out_d;
  logic [glue_pkg::delay_stages-1:0] taps;
  logic                              dly_a;
  logic                              dly_b;
  logic                              dly_c;

  assign dly_a = taps[0];
  assign dly_b = taps[1];
  assign dly_c = taps[2];

  glue_delay_chain #(
    .depth      (glue_pkg::delay_stages)
  ) u_chain (
    .clk        (clk),
    .rst_sync_n (rst_sync_n),
    .din        (refresh_mode_out_q),
    .taps       (taps)
  );

  // start only on an idle bus; hold until the chain says the slot is spent
  always_comb
  begin
    refresh_mode_out_d = 1'b0;
    if (!refresh_mode_out_q)
      refresh_mode_out_d = ~addr_act & req_act;
    else if (fast_cfg)
      refresh_mode_out_d = ~dly_c;
    else if (slow_cfg)
      refresh_mode_out_d = ~dly_a;
    else
      refresh_mode_out_d = ~dly_c;
  end

  // refresh mode flop, idle from reset so nothing fires early
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      refresh_mode_out_q <= 1'b0;
    else
      refresh_mode_out_q <= refresh_mode_out_d;
  end

  // controller mode pin; timer drops its request on seeing this low
  assign refresh_mode_out_n = ~refresh_mode_out_q;

  // ****************************************
  // row-cycle start
  // ****************************************
  // access waits one clock past refresh end for precharge;
  // slow config also fires the refresh row strobe itself
  assign row_cycle_start_n = ~((addr_act & ~refresh_mode_out_q & ~dly_a)
                               | (refresh_mode_out_q & slow_cfg & dly_a));

  // ****************************************
  // byte column strobes
  // ****************************************
  // plain gating, so each data strobe pulse of a locked cycle shows through
  assign upper_byte_col_strobe_n = ~(uds_act & cas_act);
  assign lower_byte_col_strobe_n = ~(lds_act & cas_act);

  // ****************************************
  // transfer acknowledge
  // ****************************************
  logic ack_act;

  // held off while refresh runs, and for two trailing stages except in fast config
  always_comb
  begin
    ack_act = 1'b0;
    if (!speed_select)
      ack_act = ds_any & ~refresh_mode_out_q & ~dly_a & ~dly_b;
    else if (fast_cfg)
      ack_act = cas_act & ds_any & ~refresh_mode_out_q;
    else
      ack_act = addr_act & ds_any & ~refresh_mode_out_q & ~dly_a & ~dly_b;
  end

  // released pin floats high by the board pull-up when unselected
  assign transfer_ack_n_o = ~ack_act;
  assign transfer_ack_oe  = cs_act;

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  logic        aw_held_q;
  logic        w_held_q;
  logic [3:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        do_write;

  assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_q & ~s_axi_bvalid;
  assign do_write      = aw_held_q & w_held_q & ~s_axi_bvalid;

  // address and data may arrive in either order
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      aw_held_q    <= 1'b0;
      w_held_q     <= 1'b0;
      aw_addr_q    <= 4'h0;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= glue_pkg::resp_okay;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_q == glue_pkg::ctrl_offs)
          s_axi_bresp <= glue_pkg::resp_okay;
        else
          s_axi_bresp <= glue_pkg::resp_slverr;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // control bits; a refresh start beats a software write of the request
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      soft_req_q <= glue_pkg::ctrl_reset[glue_pkg::ctrl_soft_bit];
      inhibit_q  <= glue_pkg::ctrl_reset[glue_pkg::ctrl_inh_bit];
    end
    else
    begin
      if (do_write && aw_addr_q == glue_pkg::ctrl_offs && w_strb_q[0])
      begin
        soft_req_q <= w_data_q[glue_pkg::ctrl_soft_bit];
        inhibit_q  <= w_data_q[glue_pkg::ctrl_inh_bit];
      end
      if (!refresh_mode_out_q && refresh_mode_out_d)
        soft_req_q <= 1'b0; // served once refresh mode is entered
    end
  end

  // count of refreshes started, wraps
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      refresh_count_q <= 16'h0000;
    else if (!refresh_mode_out_q && refresh_mode_out_d)
      refresh_count_q <= refresh_count_q + 16'h0001;
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  assign s_axi_arready = ~s_axi_rvalid;

  // one-cycle answer; unmapped reads give zero with slverr
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= glue_pkg::resp_okay;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= glue_pkg::resp_okay;
      if (s_axi_araddr == glue_pkg::ctrl_offs)
        s_axi_rdata <= {30'h0, inhibit_q, soft_req_q};
      else if (s_axi_araddr == glue_pkg::status_offs)
        s_axi_rdata <= {24'h0, read_write, speed_select, 1'b0, dly_c, dly_b, dly_a, 1'b0, refresh_mode_out_q};
      else if (s_axi_araddr == glue_pkg::count_offs)
        s_axi_rdata <= {16'h0, refresh_count_q};
      else
      begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= glue_pkg::resp_slverr;
      end
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

// *** glue_delay_chain.sv ***
/*
 * package of shared constants for the dram glue, plus the refresh
 * delay chain that trails the refresh-mode flop by whole cpu clocks.
 * assumes one clock and a synchronised active-low reset.
 */

// ****************************************
// shared constants
// ****************************************
package glue_pkg;
  localparam logic [3:0]  ctrl_offs     = 4'h0;
  localparam logic [3:0]  status_offs   = 4'h4;
  localparam logic [3:0]  count_offs    = 4'h8;
  localparam logic [31:0] ctrl_reset    = 32'h0000_0000;
  localparam int          ctrl_soft_bit = 0;
  localparam int          ctrl_inh_bit  = 1;
  localparam int          delay_stages  = 3;
  localparam logic [1:0]  resp_okay     = 2'h0;
  localparam logic [1:0]  resp_slverr   = 2'h2;
endpackage

`timescale 1ns/1ps

// ****************************************
// delay chain
// ****************************************
module glue_delay_chain #(
  parameter int depth = glue_pkg::delay_stages
) (
  input  wire logic             clk,
  input  wire logic             rst_sync_n,
  input  wire logic             din,
  output logic [depth-1:0]      taps
);
  // each stage copies the one before it on every clock
  genvar g;
  generate
    for (g = 0; g < depth; g++)
    begin : stage
      always_ff @(posedge clk or negedge rst_sync_n)
      begin
        if (!rst_sync_n)
          taps[g] <= 1'b0; // idle after power-up
        else if (g == 0)
          taps[g] <= din;
        else
          taps[g] <= taps[(g == 0) ? 0 : g-1];
      end
    end
  endgenerate
endmodule

// *** glue_checker_properties.sv ***
/*
 * pin checks for the dram glue, bound into dram_glue.
 * assumes cpu pins synchronous to clk.
 */
`timescale 1ns/1ps

module glue_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cpu_addr_strobe_n,
  input wire logic upper_data_strobe_n,
  input wire logic lower_data_strobe_n,
  input wire logic read_write,
  input wire logic speed_select,
  input wire logic dram_chip_select_n,
  input wire logic col_strobe_n,
  input wire logic transfer_ack_n_o,
  input wire logic transfer_ack_oe,
  input wire logic row_cycle_start_n,
  input wire logic lower_byte_col_strobe_n,
  input wire logic refresh_mode_out_n
);
  // ******
  // checks
  // ******
  logic rm;
  logic ds_n;
  logic slow;
  // short aliases; slow means both config bits high
  assign rm = refresh_mode_out_n;
  assign ds_n = upper_data_strobe_n & lower_data_strobe_n;
  assign slow = speed_select & read_write;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_two;
    !rm [*2] ##1 rm;
  endsequence
  sequence s_four;
    !rm [*4] ##1 rm;
  endsequence
  a_row_on_access:
    assert property (!cpu_addr_strobe_n && rm && $past(rm) |-> !row_cycle_start_n) else $error("row start");
  a_byte_col_gate:
    assert property (lower_byte_col_strobe_n == (lower_data_strobe_n | col_strobe_n)) else $error("byte strobe");
  a_ack_drive_en:
    assert property (transfer_ack_oe == !dram_chip_select_n) else $error("ack enable");
  a_ack_no_wait:
    assert property (!speed_select && !ds_n && rm && $past(rm) && $past(rm, 2) |-> !transfer_ack_n_o)
      else $error("ack late");
  a_ack_col_wait:
    assert property (speed_select && !read_write && rm |-> transfer_ack_n_o == (col_strobe_n | ds_n))
      else $error("ack source");
  a_ack_in_refresh:
    assert property (!rm |-> transfer_ack_n_o) else $error("ack in refresh");
  a_refresh_mode_out_slow_len:
    assert property ($fell(rm) && slow |-> s_two) else $error("slow refresh length");
  a_refresh_mode_out_fast_len:
    assert property ($fell(rm) && !slow |-> s_four) else $error("refresh length");
  a_precharge_gap:
    assert property ($rose(rm) |-> row_cycle_start_n) else $error("no precharge gap");
endmodule

bind dram_glue glue_checker u_glue_checker (
  .clk(clk), .rst_n(rst_n), .cpu_addr_strobe_n(cpu_addr_strobe_n), .upper_data_strobe_n(upper_data_strobe_n),
  .lower_data_strobe_n(lower_data_strobe_n), .read_write(read_write), .speed_select(speed_select),
  .dram_chip_select_n(dram_chip_select_n), .col_strobe_n(col_strobe_n), .transfer_ack_n_o(transfer_ack_n_o),
  .transfer_ack_oe(transfer_ack_oe), .row_cycle_start_n(row_cycle_start_n),
  .lower_byte_col_strobe_n(lower_byte_col_strobe_n), .refresh_mode_out_n(refresh_mode_out_n)
);

// *** dram_partner_model.sv ***
/*
 * far side: controller column strobe and refresh timer.
 * assumes shared clk; the timer period is a bench tick.
 */
`timescale 1ns/1ps

module dram_partner_model #(
  parameter int col_delay = 2
) (
  input  wire logic clk,
  input  wire logic row_cycle_start_n,
  input  wire logic refresh_mode_out_n,
  input  wire logic period_tick,
  output logic      col_strobe_n,
  output logic      refresh_request_n
);
  int   row_cnt_q = 0;
  logic req_q = 1'b1;
  // column strobe trails row start, drops with it
  always @(posedge clk)
    row_cnt_q <= row_cycle_start_n ? 0 : row_cnt_q + 1;
  assign col_strobe_n = row_cnt_q < col_delay;
  // request held until refresh mode is seen low
  always @(posedge clk)
    if (period_tick)
      req_q <= 1'b0;
    else if (!refresh_mode_out_n)
      req_q <= 1'b1;
  assign refresh_request_n = req_q;
endmodule

// *** tb_dram_glue.sv ***
/*
 * bench for dram_glue: cpu cycles, refreshes, axi4-lite registers.
 * assumes package, checker and partner compiled first.
 */
`timescale 1ns/1ps

module tb_dram_glue;
  localparam int cd = 2;
  logic        clk = 0, rst_n = 0, as_n = 1, uds_n = 1, lds_n = 1, rw = 1, ss = 0, cs_n = 0, tick = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        ack_n, ack_oe, col_n, req_n, row_n, lcol_n, ucol_n, rm_n, awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          n_tests = 0, n_errors = 0, k;
  wire         ack_line = ack_oe ? ack_n : 1'b1;
  always #2.5 clk = ~clk;
  dram_glue u_dram_glue (
    .clk(clk), .rst_n(rst_n), .cpu_addr_strobe_n(as_n), .upper_data_strobe_n(uds_n),
    .lower_data_strobe_n(lds_n), .read_write(rw), .speed_select(ss), .dram_chip_select_n(cs_n),
    .transfer_ack_n_o(ack_n), .transfer_ack_oe(ack_oe), .col_strobe_n(col_n), .refresh_request_n(req_n),
    .row_cycle_start_n(row_n), .upper_byte_col_strobe_n(ucol_n), .lower_byte_col_strobe_n(lcol_n),
    .refresh_mode_out_n(rm_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  dram_partner_model #(.col_delay(cd)) u_dram_partner_model (.clk(clk), .row_cycle_start_n(row_n),
    .refresh_mode_out_n(rm_n), .period_tick(tick), .col_strobe_n(col_n), .refresh_request_n(req_n));
  // ******
  // tasks
  // ******
  task automatic print_verdict();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // a used-up bound counts as a mismatch and ends the run
  task automatic guard(input int n);
    if (n == 20)
    begin
      check(0, 1);
      print_verdict();
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    // one edge between calls so bready is never driven twice in a step
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (n = 0; n < 20 && !bvalid; n++)
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 0;
      if (wready)
        wvalid <= 0;
    end
    guard(n);
    bready <= 0;
    check(bresp, er);
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ev, input logic [1:0] er);
    int n;
    // one edge between calls so rready is never driven twice in a step
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (n = 0; n < 20 && !rvalid; n++)
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 0;
    end
    guard(n);
    rready <= 0;
    check(rdata, ev);
    check(rresp, er);
  endtask
  task automatic wait_mode(input logic lvl);
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk);
      if (rm_n === lvl)
        break;
    end
    guard(k);
  endtask
  // strobes down, count clocks to acknowledge, then release
  task automatic cpu_access(output int n);
    as_n <= 0;
    uds_n <= 0;
    lds_n <= 0;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (ack_line === 1'b0)
        break;
    end
    guard(n);
    check(lcol_n, col_n);
    check(ucol_n, col_n);
    uds_n <= 1;
    lds_n <= 1;
    @(posedge clk);
    check(ack_line, 1);
    as_n <= 1;
    @(posedge clk);
  endtask
  task automatic refresh_mode_out_len(input logic s, input logic c, input int len);
    ss <= s;
    rw <= c;
    tick <= 1;
    @(posedge clk);
    tick <= 0;
    wait_mode(0);
    wait_mode(1);
    check(k + 1, len);
    repeat (3) @(posedge clk);
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    check(rm_n, 1);
    axi_rd(glue_pkg::ctrl_offs, glue_pkg::ctrl_reset, glue_pkg::resp_okay);
    axi_rd(4'hc, 0, glue_pkg::resp_slverr);
    axi_wr(4'hc, 1, glue_pkg::resp_slverr);
    cpu_access(k);
    check(k, 0);
    // held address strobe, data strobe twice
    as_n <= 0;
    lds_n <= 0;
    repeat (cd + 1) @(posedge clk);
    check(lcol_n, 0);
    lds_n <= 1;
    @(posedge clk);
    check(lcol_n, 1);
    lds_n <= 0;
    rw <= 0;
    @(posedge clk);
    check(lcol_n, 0);
    lds_n <= 1;
    as_n <= 1;
    ss <= 1;
    @(posedge clk);
    cpu_access(k);
    check(k, cd);
    refresh_mode_out_len(0, 1, 4);
    refresh_mode_out_len(1, 0, 4);
    refresh_mode_out_len(1, 1, 2);
    cpu_access(k);
    check(k, 0);
    // access lands on a timer refresh
    tick <= 1;
    @(posedge clk);
    tick <= 0;
    wait_mode(0);
    cpu_access(k);
    check(k > 0, 1);
    axi_wr(glue_pkg::ctrl_offs, 1 << glue_pkg::ctrl_soft_bit, glue_pkg::resp_okay);
    wait_mode(0);
    wait_mode(1);
    axi_rd(glue_pkg::ctrl_offs, 0, glue_pkg::resp_okay);
    axi_rd(glue_pkg::count_offs, 5, glue_pkg::resp_okay);
    axi_rd(glue_pkg::status_offs, 32'h0000_00c0, glue_pkg::resp_okay);
    cs_n <= 1;
    as_n <= 0;
    @(posedge clk);
    check({ack_oe, ack_line}, 2'b01);
    print_verdict();
  end
endmodule
